// File: hdl/program_space_read_paging_pkg.sv
package program_space_read_paging_pkg;

	localparam int unsigned PROG_ADDR_W  = 24;
	localparam int unsigned DATA_W       = 16;
	localparam int unsigned LOC_W        = 24;
	localparam int unsigned PAGE_W       = 10;
	localparam int unsigned PAGE_EN_BIT  = 9;
	localparam int unsigned VIEW_SEL_BIT = 15;
	localparam int unsigned OFFSET_W     = 15;
	localparam int unsigned PAGE_LOW_W   = 9;

	localparam logic [PROG_ADDR_W-1:0] RESET_VECTOR_ADDR = 24'h000000;
	localparam logic [PROG_ADDR_W-1:0] START_SLOT_ADDR   = 24'h000002;
	localparam logic [PROG_ADDR_W-1:0] VECTOR_END_ADDR   = 24'h000200;
	localparam logic [PROG_ADDR_W-1:0] PC_STEP           = 24'h000002;
	localparam logic [PAGE_W-1:0]      PAGE_RESET        = 10'h000;
	localparam logic [PAGE_W-1:0]      VIEW_MIN_PAGE     = 10'h200;
	localparam logic [DATA_W-1:0]      PAGE_REG_ADDR     = 16'h0032;
	localparam logic [7:0]             UPPER_PAD         = 8'h00;

	typedef enum logic [1:0] {
		STEP_HOLD,
		STEP_UP,
		STEP_DOWN
	} step_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [DATA_W-1:0] effective_address;
		logic [DATA_W-1:0] wdata;
	} ds_req_t;

	typedef struct packed {
		logic                   valid;
		logic [PROG_ADDR_W-1:0] addr;
		logic [LOC_W-1:0]       word;
		logic                   in_vector;
	} fetch_out_t;

endpackage

// File: hdl/program_store.sv
`timescale 1ns/1ps
`default_nettype none

module program_store #(
	parameter int unsigned AW = 14,
	parameter int unsigned DW = 24
) (
	input  wire logic          clk_sys,
	input  wire logic          load_en,
	input  wire logic [AW-1:0] load_index,
	input  wire logic [DW-1:0] load_word,
	input  wire logic [AW-1:0] a_index,
	output var  logic [DW-1:0] a_word_q,
	input  wire logic [AW-1:0] b_index,
	output var  logic [DW-1:0] b_word_q
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_sys) begin
		if (load_en) begin
			mem[load_index] <= load_word;
		end
	end

	always_ff @(posedge clk_sys) begin
		a_word_q <= mem[a_index];
		b_word_q <= mem[b_index];
	end

endmodule // program_store

`default_nettype wire

// File: hdl/program_space_read_paging.sv
// Contract
// - Each program location is 24 bits: lower word, upper word, top byte empty.
// - Lower word sits at the even address, upper word at the next odd one.
// - Program counter stays even and steps by two up or down.
// - Addresses 0x000000 up to but not including 0x000200 are the fixed vector area.
// - After reset fetch at zero; jump target comes from location 0x000002.
// - Modified effective addresses walk linearly through one page, no reload.
// - Page bit 9 and address bit 15 set: page 8:0 over address 14:0.
// - Each page value of 0x200 or more opens its own 32 KB window in upper data space.
// - Program space is reached only with a page of 0x200 or more.
// - Only reads go through the page window; writes there are refused.
// - Page register sits in peripheral space, written by data writes.
`timescale 1ns/1ps
`default_nettype none

module program_space_read_paging #(
	parameter int unsigned MEM_AW = 14
) (
	input  wire logic                                            clk_sys,
	input  wire logic                                            resetn,
	input  wire program_space_read_paging_pkg::ds_req_t          ds_req,
	input  wire program_space_read_paging_pkg::step_t            fetch_step,
	input  wire logic                                            load_en,
	input  wire logic [MEM_AW-1:0]                               load_index,
	input  wire logic [program_space_read_paging_pkg::LOC_W-1:0] load_word,
	output var  program_space_read_paging_pkg::ds_req_t          ds_pass_q,
	output var  logic                                            rd_valid_q,
	output var  logic [program_space_read_paging_pkg::DATA_W-1:0] rd_data_q,
	output var  logic                                            write_refused_q,
	output var  logic [program_space_read_paging_pkg::PAGE_W-1:0] read_page_register_q,
	output var  program_space_read_paging_pkg::fetch_out_t       fetch_q
);

	typedef enum logic [1:0] {
		BOOT_JUMP,
		BOOT_SLOT,
		BOOT_LOAD,
		BOOT_RUN
	} boot_t;

	localparam int unsigned AW  = program_space_read_paging_pkg::PROG_ADDR_W;
	localparam int unsigned DW  = program_space_read_paging_pkg::DATA_W;
	localparam int unsigned LW  = program_space_read_paging_pkg::LOC_W;

	function automatic logic [MEM_AW-1:0] loc_index(input logic [AW-1:0] a);
		loc_index = a[MEM_AW:1];
	endfunction

	// Window open test
	function automatic logic view_open(
		input logic [program_space_read_paging_pkg::PAGE_W-1:0] page,
		input logic [DW-1:0]                                    ea
	);
		view_open = ea[program_space_read_paging_pkg::VIEW_SEL_BIT]
			&& (page >= program_space_read_paging_pkg::VIEW_MIN_PAGE);
	endfunction

	// Window address: page bits over offset bits
	function automatic logic [AW-1:0] view_address(
		input logic [program_space_read_paging_pkg::PAGE_W-1:0] page,
		input logic [DW-1:0]                                    ea
	);
		view_address = {page[program_space_read_paging_pkg::PAGE_LOW_W-1:0],
			ea[program_space_read_paging_pkg::OFFSET_W-1:0]};
	endfunction

	// Half of a location seen at an even or odd address
	function automatic logic [DW-1:0] half_word(
		input logic [LW-1:0] word,
		input logic          odd
	);
		half_word = odd ? {program_space_read_paging_pkg::UPPER_PAD,
			word[LW-1:DW]} : word[DW-1:0];
	endfunction

	// Program counter step
	function automatic logic [AW-1:0] next_pc(
		input logic [AW-1:0]                        pc,
		input program_space_read_paging_pkg::step_t step
	);
		unique case (step)
		program_space_read_paging_pkg::STEP_UP: begin
			next_pc = pc + program_space_read_paging_pkg::PC_STEP;
		end
		program_space_read_paging_pkg::STEP_DOWN: begin
			next_pc = pc - program_space_read_paging_pkg::PC_STEP;
		end
		default: begin
			next_pc = pc;
		end
		endcase
	endfunction

	boot_t              boot_q;
	logic [AW-1:0]      pc_q;
	logic [AW-1:0]      a_addr_q;
	logic               a_live_q;
	logic [LW-1:0]      a_word;
	logic [LW-1:0]      b_word;
	logic               view_hit;
	logic               page_hit;
	logic [AW-1:0]      view_addr;
	logic               view_pend_q;
	logic               view_odd_q;
	logic               page_pend_q;
	logic [AW-1:0]      target;

	// Window decode and address build
	assign view_hit  = view_open(read_page_register_q,
		ds_req.effective_address);
	assign page_hit  = ds_req.effective_address ==
		program_space_read_paging_pkg::PAGE_REG_ADDR;
	assign view_addr = view_address(read_page_register_q,
		ds_req.effective_address);

	// Start address: lower word plus low byte of upper word of the slot
	assign target = {a_word[LW-1:DW], a_word[DW-1:1], 1'b0};

	program_store #(
		.AW (MEM_AW),
		.DW (LW)
	) u_store (
		.clk_sys    (clk_sys),
		.load_en    (load_en),
		.load_index (load_index),
		.load_word  (load_word),
		.a_index    (loc_index(pc_q)),
		.a_word_q   (a_word),
		.b_index    (loc_index(view_addr)),
		.b_word_q   (b_word)
	);

	// Page register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			read_page_register_q <= program_space_read_paging_pkg::PAGE_RESET;
		end else if (ds_req.valid && ds_req.write && page_hit) begin
			read_page_register_q <= ds_req.wdata[
				program_space_read_paging_pkg::PAGE_W-1:0];
		end
	end

	// Data-space routing
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ds_pass_q       <= '0;
			write_refused_q <= 1'b0;
			view_pend_q     <= 1'b0;
			view_odd_q      <= 1'b0;
			page_pend_q     <= 1'b0;
		end else begin
			ds_pass_q       <= ds_req;
			ds_pass_q.valid <= ds_req.valid && !view_hit && !page_hit;
			write_refused_q <= ds_req.valid && ds_req.write && view_hit;
			view_pend_q     <= ds_req.valid && !ds_req.write && view_hit;
			view_odd_q      <= view_addr[0];
			page_pend_q     <= ds_req.valid && !ds_req.write && page_hit
				&& !view_hit;
		end
	end

	// Read answer: view data or page register readback
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= '0;
		end else begin
			rd_valid_q <= view_pend_q || page_pend_q;
			if (view_pend_q) begin
				rd_data_q <= half_word(b_word, view_odd_q);
			end else if (page_pend_q) begin
				rd_data_q <= {{(DW-program_space_read_paging_pkg::PAGE_W){1'b0}},
					read_page_register_q};
			end
		end
	end

	// Reset-vector boot and program counter
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			boot_q <= BOOT_JUMP;
			pc_q   <= program_space_read_paging_pkg::RESET_VECTOR_ADDR;
		end else begin
			unique case (boot_q)
			BOOT_JUMP: begin
				boot_q <= BOOT_SLOT;
				pc_q   <= program_space_read_paging_pkg::START_SLOT_ADDR;
			end
			BOOT_SLOT: begin
				boot_q <= BOOT_LOAD;
			end
			BOOT_LOAD: begin
				boot_q <= BOOT_RUN;
				pc_q   <= target;
			end
			BOOT_RUN: begin
				pc_q <= next_pc(pc_q, fetch_step);
			end
			endcase
		end
	end

	// Fetch output, one cycle behind the store read
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			a_addr_q <= '0;
			a_live_q <= 1'b0;
			fetch_q  <= '0;
		end else begin
			a_addr_q          <= pc_q;
			a_live_q          <= boot_q == BOOT_RUN;
			fetch_q.valid     <= a_live_q;
			fetch_q.addr      <= a_addr_q;
			fetch_q.word      <= a_word;
			fetch_q.in_vector <= a_addr_q <
				program_space_read_paging_pkg::VECTOR_END_ADDR;
		end
	end

endmodule // program_space_read_paging

`default_nettype wire

// File: tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire program_space_read_paging_pkg::ds_req_t op,
	input  wire logic                                   clk_sys,
	output var  program_space_read_paging_pkg::ds_req_t ds_req
);
	// Core issues each queued access one edge later, one per cycle
	always_ff @(posedge clk_sys) begin
		ds_req <= op;
	end
endmodule // core_model
`default_nettype wire

// File: tb/paging_chk.sv
`timescale 1ns/1ps
`default_nettype none
module paging_chk (
	input wire logic                                      clk_sys,
	input wire logic                                      resetn,
	input wire program_space_read_paging_pkg::ds_req_t    ds_req,
	input wire program_space_read_paging_pkg::ds_req_t    ds_pass_q,
	input wire logic                                      rd_valid_q,
	input wire logic                                      write_refused_q,
	input wire logic [9:0]                                read_page_register_q,
	input wire program_space_read_paging_pkg::fetch_out_t fetch_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire logic win = ds_req.valid && ds_req.effective_address[15]
		&& read_page_register_q[9];
	sequence win_rd;
		win && !ds_req.write;
	endsequence
	sequence pg_wr;
		ds_req.valid && ds_req.write && ds_req.effective_address == 16'h0032;
	endsequence
	a_win_read: assert property (win_rd |-> ##2 rd_valid_q)
		else $error("window read unanswered");
	a_win_refuse: assert property (win && ds_req.write |=> write_refused_q)
		else $error("window write not refused");
	a_win_hidden: assert property (win |=> !ds_pass_q.valid)
		else $error("window access passed");
	a_plain_pass: assert property (
		ds_req.valid && !win && ds_req.effective_address != 16'h0032
		|=> ds_pass_q.valid) else $error("plain access lost");
	a_page_load: assert property (
		pg_wr |=> read_page_register_q == $past(ds_req.wdata[9:0]))
		else $error("page not loaded");
	a_page_reset: assert property (
		$rose(resetn) |-> read_page_register_q == 10'h000)
		else $error("page not cleared");
	a_pc_even: assert property (fetch_q.valid |-> !fetch_q.addr[0])
		else $error("odd fetch address");
	a_pc_step: assert property (
		fetch_q.valid && $past(fetch_q.valid) |-> fetch_q.addr - $past(fetch_q.addr)
		inside {24'h000000, 24'h000002, 24'hfffffe}) else $error("bad step");
endmodule // paging_chk
bind program_space_read_paging paging_chk u_chk (.clk_sys, .resetn, .ds_req,
	.ds_pass_q, .rd_valid_q, .write_refused_q, .read_page_register_q, .fetch_q);
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
	$display("Error %0t %h %h", $time, a, e); end end
module testbench;
	typedef struct packed {
		logic wr; logic [15:0] ea; logic [15:0] wd; logic [1:0] kind;
		logic [15:0] exp;
	} row_t;
	logic                                       clk_sys = 1'b0;
	logic                                       resetn = 1'b0;
	program_space_read_paging_pkg::ds_req_t     op = '0;
	program_space_read_paging_pkg::ds_req_t     ds_req, ds_pass_q;
	program_space_read_paging_pkg::step_t       step =
		program_space_read_paging_pkg::STEP_HOLD;
	logic                                       load_en = 1'b0;
	logic [5:0]                                 load_index = 6'h00;
	logic [23:0]                                load_word = 24'h000000;
	logic                                       rd_valid_q, write_refused_q;
	logic [15:0]                                rd_data_q;
	logic [9:0]                                 read_page_register_q;
	program_space_read_paging_pkg::fetch_out_t  fetch_q;
	int                                         fail_count = 0;
	int                                         check_count = 0;
	// Kind: 0 passed, 1 answered, 2 refused, 3 page load
	row_t rows [10] = '{'{1'b1, 16'h0032, 16'h0200, 2'h3, 16'h0000},
		'{1'b0, 16'h8004, 16'h0000, 2'h1, 16'h3c02},
		'{1'b0, 16'h8005, 16'h0000, 2'h1, 16'h0002},
		'{1'b0, 16'h8006, 16'h0000, 2'h1, 16'h3c03},
		'{1'b1, 16'h8006, 16'h1234, 2'h2, 16'h0000},
		'{1'b0, 16'h0032, 16'h0000, 2'h1, 16'h0200},
		'{1'b0, 16'h1234, 16'h0000, 2'h0, 16'h0000},
		'{1'b1, 16'h0032, 16'h01ff, 2'h3, 16'h0000},
		'{1'b0, 16'h8004, 16'h0000, 2'h0, 16'h0000},
		'{1'b1, 16'h8004, 16'h0055, 2'h0, 16'h0000}};
	core_model u_core (.clk_sys(clk_sys), .op(op), .ds_req(ds_req));
	program_space_read_paging #(.MEM_AW(6)) u_dut (.clk_sys(clk_sys),
		.resetn(resetn), .ds_req(ds_req), .fetch_step(step),
		.load_en(load_en), .load_index(load_index), .load_word(load_word),
		.ds_pass_q(ds_pass_q), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
		.write_refused_q(write_refused_q), .fetch_q(fetch_q),
		.read_page_register_q(read_page_register_q));
	function automatic logic [23:0] loc(input logic [5:0] i);
		return (i == 6'h01) ? 24'h000010 : {2'h0, i, 8'h3c, 2'h0, i};
	endfunction
	task automatic results;
		if (fail_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wait_fetch;
		for (int n = 0; fetch_q.valid !== 1'b1; n++) begin
			@(posedge clk_sys);
			#1;
			if (n == 20) begin
				fail_count++;
				results();
			end
		end
	endtask
	task automatic walk(input program_space_read_paging_pkg::step_t s,
		input int n, input logic [5:0] idx);
		@(posedge clk_sys);
		step <= s;
		repeat (n) @(posedge clk_sys);
		step <= program_space_read_paging_pkg::STEP_HOLD;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK(fetch_q.addr, {17'h0, idx, 1'b0})
		`CHK(fetch_q.word, loc(idx))
	endtask
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		for (int k = 0; k < 12; k++) begin
			@(posedge clk_sys);
			load_en <= 1'b1;
			load_index <= 6'(k);
			load_word <= loc(6'(k));
			if (k == 11) resetn <= 1'b1;
		end
		@(posedge clk_sys);
		load_en <= 1'b0;
		wait_fetch();
		`CHK(fetch_q.addr, 24'h000010)
		`CHK(fetch_q.word, loc(6'h08))
		`CHK(fetch_q.in_vector, 1'b1)
		walk(program_space_read_paging_pkg::STEP_UP, 1, 6'h09);
		walk(program_space_read_paging_pkg::STEP_DOWN, 2, 6'h07);
		for (int i = 0; i < 13; i++) begin
			@(posedge clk_sys);
			op <= (i < 10) ? {1'b1, rows[i].wr, rows[i].ea, rows[i].wd} : 34'h0;
			#1;
			if (i >= 2 && i < 12) begin
				`CHK(ds_pass_q.valid, rows[i-2].kind == 2'h0)
				`CHK(write_refused_q, rows[i-2].kind == 2'h2)
				if (rows[i-2].kind == 2'h0) begin
					`CHK(ds_pass_q[32:0], rows[i-2][50:18])
				end
			end
			if (i >= 3) begin
				`CHK(rd_valid_q, rows[i-3].kind == 2'h1)
				if (rows[i-3].kind == 2'h1) `CHK(rd_data_q, rows[i-3].exp)
			end
		end
		`CHK(read_page_register_q, 10'h1ff)
		@(posedge clk_sys);
		resetn <= 1'b0;
		load_en <= 1'b1;
		load_index <= 6'h01;
		load_word <= 24'h000210;
		@(posedge clk_sys);
		load_en <= 1'b0;
		#1;
		`CHK(read_page_register_q, 10'h000)
		`CHK(fetch_q.valid, 1'b0)
		`CHK({ds_pass_q.valid, rd_valid_q, write_refused_q}, 3'h0)
		@(posedge clk_sys);
		resetn <= 1'b1;
		wait_fetch();
		`CHK(fetch_q.addr, 24'h000210)
		`CHK(fetch_q.word, loc(6'h08))
		`CHK(fetch_q.in_vector, 1'b0)
		results();
	end
endmodule // testbench
`default_nettype wire
